// file: multimode_timer_bank.sv
// Six-channel multimode timer bank with an AXI4-Lite register slave
// Function
// - Three modes chosen per channel by field
// - Timer mode uses seven internal count sources
// - Count down, reload on underflow, request interrupt
// - Underflow period is n+1 source ticks
// - Run bit 1 starts, 0 stops counting
// - Run bits at 5..7 of two start registers
// - Count register read returns current count
// - Stopped write loads reload and counter
// - Running write loads reload only
// - Event mode counts selected pin edges
// - Event mode may count predecessor underflows
// - Measure: count up, capture and clear on edge
// - Measure: request each edge except first
// - Measure overflow sets flag and requests
// - Measure read returns last captured value
// - Measure write changes nothing
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module multimode_timer_bank #(
	parameter int ADDR_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic [5:0] channel_input_pin,
	input wire logic slow_onchip_osc_clock,
	input wire logic subclock_source,
	output logic [5:0] irq_request
);

	localparam int N = timer_bank_pkg::NUM_CH;

	// Whole state of the slave and the shared control registers
	typedef struct packed {
		logic aw_got;
		logic [7:0] waddr;
		logic w_got;
		logic [31:0] wdat;
		logic [3:0] wstb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [N-1:0] run;
		timer_bank_pkg::cfg_s [N-1:0] cfg;
		logic [N-1:0] pin_s1;
		logic [N-1:0] pin_s2;
	} top_s;

	top_s st;
	top_s next_st;
	logic [7:0] ticks;
	logic [N-1:0][15:0] count_rd;
	logic [N-1:0] ovf;
	logic [N-1:0] uf;
	logic [N-1:0] irq;
	logic [N-1:0] wr_cnt;
	logic [N-1:0] clr_ovf;
	logic [15:0] wval;
	logic [31:0] mask;
	logic [31:0] merged;
	logic [2:0] widx;
	logic [7:0] wa;
	logic [7:0] ra;

	// Address of a channel's register pair, byte offset to index
	function automatic logic [2:0] ch_index(input logic [7:0] a);
		logic [7:0] off;
		off = a - timer_bank_pkg::CH_BASE_OFFSET;
		return off[timer_bank_pkg::CH_INDEX_LSB +: 3];
	endfunction : ch_index

	// Channel window check
	function automatic logic in_ch(input logic [7:0] a);
		return (a >= timer_bank_pkg::CH_BASE_OFFSET) && (a < timer_bank_pkg::CH_END_OFFSET)
			&& (a[1:0] == 2'h0);
	endfunction : in_ch

	// Whether an offset names a register
	function automatic logic mapped(input logic [7:0] a);
		return (a == timer_bank_pkg::START_LOW_OFFSET) || (a == timer_bank_pkg::START_HIGH_OFFSET)
			|| in_ch(a);
	endfunction : mapped

	// Register read mux, unmapped and reserved bits read zero
	function automatic logic [31:0] reg_read(input logic [7:0] a);
		logic [31:0] v;
		logic [2:0] i;
		v = '0;
		i = ch_index(a);
		if (a == timer_bank_pkg::START_LOW_OFFSET) begin
			v[timer_bank_pkg::RUN_LSB +: 3] = st.run[2:0];
		end else if (a == timer_bank_pkg::START_HIGH_OFFSET) begin
			v[timer_bank_pkg::RUN_LSB +: 3] = st.run[5:3];
		end else if (in_ch(a)) begin
			if (a[timer_bank_pkg::COUNT_SEL_BIT]) begin
				v[15:0] = count_rd[i];
			end else begin
				v[timer_bank_pkg::MODE_LSB +: 2] = st.cfg[i].mode;
				v[timer_bank_pkg::EDGE_LSB +: 2] = st.cfg[i].edge_sel;
				v[timer_bank_pkg::OVF_BIT] = ovf[i];
				v[timer_bank_pkg::PRED_BIT] = st.cfg[i].ev_pred;
				v[timer_bank_pkg::SRC_LSB +: 3] = st.cfg[i].clk_src;
			end
		end
		return v;
	endfunction : reg_read

	// Low address bits seen by the decoder
	assign wa = st.waddr;
	assign ra = araddr[7:0];

	// Channel ready terms follow the held request slots
	assign awready = !st.aw_got && !st.bvalid;
	assign wready = !st.w_got && !st.bvalid;
	assign arready = !st.rvalid;

	// Byte lane mask and merge of a held write with the current contents
	always_comb begin
		mask = {{8{st.wstb[3]}}, {8{st.wstb[2]}}, {8{st.wstb[1]}}, {8{st.wstb[0]}}};
		merged = (reg_read(wa) & ~mask) | (st.wdat & mask);
		widx = ch_index(wa);
		wval = merged[15:0];
	end

	// Slave sequencing, register writes and pin synchronisers
	always_comb begin
		next_st = st;
		wr_cnt = '0;
		clr_ovf = '0;
		next_st.pin_s1 = channel_input_pin;
		next_st.pin_s2 = st.pin_s1;
		// Capture address and data in either order
		if (awvalid && awready) begin
			next_st.aw_got = 1'b1;
			next_st.waddr = awaddr[7:0];
		end
		if (wvalid && wready) begin
			next_st.w_got = 1'b1;
			next_st.wdat = wdata;
			next_st.wstb = wstrb;
		end
		// Perform the write once both halves are held
		if (st.aw_got && st.w_got && !st.bvalid) begin
			next_st.aw_got = 1'b0;
			next_st.w_got = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = mapped(wa) ? timer_bank_pkg::RESP_OKAY : timer_bank_pkg::RESP_SLVERR;
			if (wa == timer_bank_pkg::START_LOW_OFFSET) begin
				next_st.run[2:0] = merged[timer_bank_pkg::RUN_LSB +: 3];
			end else if (wa == timer_bank_pkg::START_HIGH_OFFSET) begin
				next_st.run[5:3] = merged[timer_bank_pkg::RUN_LSB +: 3];
			end else if (in_ch(wa)) begin
				if (wa[timer_bank_pkg::COUNT_SEL_BIT]) begin
					wr_cnt[widx] = 1'b1;
				end else begin
					next_st.cfg[widx].mode =
						timer_bank_pkg::mode_e'(merged[timer_bank_pkg::MODE_LSB +: 2]);
					next_st.cfg[widx].edge_sel = merged[timer_bank_pkg::EDGE_LSB +: 2];
					next_st.cfg[widx].ev_pred = merged[timer_bank_pkg::PRED_BIT];
					next_st.cfg[widx].clk_src = merged[timer_bank_pkg::SRC_LSB +: 3];
					clr_ovf[widx] = !merged[timer_bank_pkg::OVF_BIT];
				end
			end
		end
		if (st.bvalid && bready) begin
			next_st.bvalid = 1'b0;
		end
		// Read answer taken from the live state
		if (arvalid && arready) begin
			next_st.rvalid = 1'b1;
			next_st.rdata = reg_read(ra);
			next_st.rresp = mapped(ra) ? timer_bank_pkg::RESP_OKAY : timer_bank_pkg::RESP_SLVERR;
		end else if (st.rvalid && rready) begin
			next_st.rvalid = 1'b0;
		end
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '{cfg: {N{timer_bank_pkg::CFG_RESET}}, default: '0};
		end else begin
			st <= next_st;
		end
	end

	// Bus outputs straight from flip-flops
	assign bvalid = st.bvalid;
	assign bresp = st.bresp;
	assign rvalid = st.rvalid;
	assign rdata = st.rdata;
	assign rresp = st.rresp;
	assign irq_request = irq;

	// Shared count sources
	timer_tick_source u_ticks (
		.aclk(aclk),
		.aresetn(aresetn),
		.slow_onchip_osc_clock(slow_onchip_osc_clock),
		.subclock_source(subclock_source),
		.ticks(ticks)
	);

	// Six channels in two cascaded rings of three
	for (genvar g = 0; g < N; g++) begin : g_ch
		localparam int PRED = (g % timer_bank_pkg::GROUP_SIZE == 0) ?
			g + timer_bank_pkg::GROUP_SIZE - 1 : g - 1;
		timer_channel u_ch (
			.aclk(aclk),
			.aresetn(aresetn),
			.cfg(st.cfg[g]),
			.run(st.run[g]),
			.ticks(ticks),
			.pin(st.pin_s2[g]),
			.pred_uf(uf[PRED]),
			.wr(wr_cnt[g]),
			.wval(wval),
			.clr_ovf(clr_ovf[g]),
			.count_rd(count_rd[g]),
			.ovf(ovf[g]),
			.uf(uf[g]),
			.irq(irq[g])
		);
	end

endmodule : multimode_timer_bank

// file: pulse_source.sv
// External pulse source for the channel input pins
`timescale 1ns/1ps
module pulse_source (
	input wire logic aclk,
	input wire logic [5:0] en,
	input wire logic [7:0] half,
	output logic [5:0] pin
);
	logic [7:0] cnt = 8'h00;
	initial pin = 6'h00;
	// Toggle enabled pins each half period, idle low otherwise
	always @(posedge aclk) begin
		cnt <= (cnt + 8'h01 >= half) ? 8'h00 : cnt + 8'h01;
		for (int i = 0; i < 6; i++) begin
			if (!en[i])
				pin[i] <= 1'b0;
			else if (cnt + 8'h01 >= half)
				pin[i] <= ~pin[i];
		end
	end
endmodule : pulse_source

// file: testbench.sv
// Self-checking bench for the six-channel timer bank
`timescale 1ns/1ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
	$display("MISMATCH %s expected %h seen %h", n, e, a); end end
module testbench;
	localparam int H = 6;
	localparam logic [1:0] OK = timer_bank_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = timer_bank_pkg::RESP_SLVERR;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, slow = 1'b0, sub = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, v;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, exp_b;
	logic [5:0] irq_request, pins, acc, runs = 6'h00, en = 6'h1f;
	logic [33:0] exp_r;
	logic [33:0] rq [$];
	logic [1:0] bq [$];
	int c, s, e, t, cyc = 0, seed = 98582, err_count = 0, cmp_count = 0;
	int dv [7] = '{1, 2, 8, 32, 64, 10, 14};
	multimode_timer_bank dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
		.wdata(wdata), .wstrb(4'hf), .bvalid(bvalid), .bready(1'b1), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
		.rready(1'b1), .rdata(rdata), .rresp(rresp), .channel_input_pin(pins),
		.slow_onchip_osc_clock(slow), .subclock_source(sub), .irq_request(irq_request));
	pulse_source src (.aclk(aclk), .en(en), .half(8'(H)), .pin(pins));
	always #4 aclk = ~aclk;
	// Cycle count, slow count sources and hang limit
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		slow <= (cyc % 10) < 5;
		sub <= (cyc % 14) < 7;
		if (cyc == 20000) begin
			err_count++;
			tally_and_finish();
		end
	end
	// Oldest noted answer against each bus response
	always @(posedge aclk) begin
		if (rvalid) begin
			exp_r = rq.pop_front();
			`CHK("read", exp_r, {rresp, rdata})
		end
		if (bvalid) begin
			exp_b = bq.pop_front();
			`CHK("bresp", exp_b, bresp)
		end
	end
	task automatic tally_and_finish();
		$display("compares %0d errors %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		bq.push_back(r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid)
				break;
		end
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		rq.push_back({r, d});
		araddr <= a;
		arvalid <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid)
				break;
		end
	endtask : rd
	task automatic go(input int c, input logic on);
		runs[c] = on;
		wr((c < 3) ? 8'h00 : 8'h04, {24'h0, runs[(c / 3) * 3 +: 3], 5'h0}, OK);
	endtask : go
	task automatic wirq(input int c, output int t);
		t = 0;
		do begin
			@(posedge aclk);
			t++;
		end while (irq_request[c] !== 1'b1);
	endtask : wirq
	function automatic logic [7:0] ma(input int c);
		return 8'(8'h10 + 8 * c);
	endfunction : ma
	function automatic logic [31:0] mv(input int src, input int pred, input int e, input int m);
		return 32'((src << 8) | (pred << 7) | (e << 2) | m);
	endfunction : mv
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		// Reset contents and unmapped places
		for (c = 0; c < 6; c++) begin
			rd(ma(c), 32'h0, OK);
			rd(ma(c) + 8'h04, 32'h0, OK);
		end
		wr(8'h0c, 32'h1, ERR);
		rd(8'h08, 32'h0, ERR);
		// Every count source, every run bit, n equal to the source index
		for (s = 0; s < 7; s++) begin
			c = s % 6;
			wr(ma(c), mv(s, 0, 0, 0), OK);
			wr(ma(c) + 8'h04, 32'(s), OK);
			go(c, 1'b1);
			wirq(c, t);
			wirq(c, t);
			`CHK("timer period", (s + 1) * dv[s], t)
			go(c, 1'b0);
		end
		// Channel 3 runs in the idle mode, nothing may count
		wr(ma(3), mv(0, 0, 0, 3), OK);
		go(3, 1'b1);
		acc = 6'h00;
		repeat (100) begin
			@(posedge aclk);
			acc |= irq_request;
		end
		`CHK("stopped irq", 6'h00, acc)
		go(3, 1'b0);
		// Stopped load on a div1 source, then running reload update
		wr(ma(0), mv(0, 0, 0, 0), OK);
		v = (32'($random(seed)) & 32'hff) | 32'h10;
		wr(8'h14, v, OK);
		rd(8'h14, v, OK);
		go(0, 1'b1);
		wirq(0, t);
		wr(8'h14, 32'h7, OK);
		wirq(0, t);
		wirq(0, t);
		`CHK("reload period", 8, t)
		go(0, 1'b0);
		// Pin edges of each kind
		for (e = 0; e < 3; e++) begin
			wr(ma(1), mv(0, 0, e, 1), OK);
			wr(ma(1) + 8'h04, 32'h2, OK);
			go(1, 1'b1);
			wirq(1, t);
			wirq(1, t);
			`CHK("event period", (e == 2) ? 3 * H : 6 * H, t)
			go(1, 1'b0);
		end
		// Channel 0 counts underflows of channel 2
		wr(ma(2), mv(0, 0, 0, 0), OK);
		wr(ma(2) + 8'h04, 32'h1, OK);
		wr(ma(0), mv(0, 1, 0, 1), OK);
		wr(ma(0) + 8'h04, 32'h2, OK);
		go(0, 1'b1);
		go(2, 1'b1);
		wirq(0, t);
		wirq(0, t);
		`CHK("cascade period", 6, t)
		go(0, 1'b0);
		go(2, 1'b0);
		// Period and width measurement
		en <= 6'h00;
		wr(ma(4), mv(0, 0, 0, 2), OK);
		go(4, 1'b1);
		en <= 6'h1f;
		wirq(4, t);
		`CHK("first edge", 1'b1, t > 2 * H)
		wirq(4, t);
		`CHK("period", 2 * H, t)
		rd(ma(4) + 8'h04, 32'(2 * H - 1), OK);
		wr(ma(4) + 8'h04, 32'($random(seed)), OK);
		rd(ma(4) + 8'h04, 32'(2 * H - 1), OK);
		wr(ma(4), mv(0, 0, 2, 2), OK);
		wirq(4, t);
		wirq(4, t);
		`CHK("width", H, t)
		rd(ma(4) + 8'h04, 32'(H - 1), OK);
		go(4, 1'b0);
		// Overflow from a preloaded count, flag held across later edges
		wr(ma(5), mv(0, 0, 0, 0), OK);
		wr(ma(5) + 8'h04, 32'hfff0, OK);
		wr(ma(5), mv(0, 0, 0, 2), OK);
		go(5, 1'b1);
		wirq(5, t);
		rd(ma(5), 32'h22, OK);
		en <= 6'h3f;
		repeat (50) @(posedge aclk);
		rd(ma(5), 32'h22, OK);
		wr(ma(5), 32'h02, OK);
		rd(ma(5), 32'h02, OK);
		tally_and_finish();
	end
endmodule : testbench

// file: timer_bank_checker.sv
// Port checks on the timer bank's bus and interrupt outputs
`timescale 1ns/1ps
module timer_bank_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic [5:0] irq_request
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	logic [1:0] pend;
	// Writes taken but not yet answered
	always_ff @(posedge aclk) begin
		if (!aresetn)
			pend <= 2'h0;
		else
			pend <= 2'(pend + (awvalid && awready) - (bvalid && bready));
	end
	reset_quiet_a: assert property ($rose(aresetn) |-> irq_request == 6'h00 && !bvalid)
		else $error("activity right after reset");
	write_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("write answer late");
	resp_drop_a: assert property (bvalid && bready |=> !bvalid)
		else $error("write answer repeated");
	bus_refuse_a: assert property (bvalid |-> !awready && !wready)
		else $error("write taken during answer");
	read_answer_a: assert property (arvalid && arready |=> rvalid ##1 !rvalid)
		else $error("read answer timing");
	read_refuse_a: assert property (rvalid |-> !arready)
		else $error("read taken during answer");
	unmapped_zero_a: assert property (rvalid && rresp == timer_bank_pkg::RESP_SLVERR |-> rdata == 32'h0)
		else $error("unmapped read not zero");
	one_write_a: assert property (pend <= 2'h1)
		else $error("two writes outstanding");
	cover property (bvalid && bresp == timer_bank_pkg::RESP_SLVERR);
	cover property (rvalid && rready);
	cover property (irq_request != 6'h00);
endmodule : timer_bank_checker

bind multimode_timer_bank timer_bank_checker chk (.aclk(aclk), .aresetn(aresetn),
	.awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
	.bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
	.rready(rready), .rdata(rdata), .rresp(rresp), .irq_request(irq_request));

// file: timer_bank_pkg.sv
// Shared constants, field layouts and carrier types of the six-channel timer bank
package timer_bank_pkg;

	// Channel count and grouping
	localparam int NUM_CH = 6;
	localparam int GROUP_SIZE = 3;

	// Register byte offsets
	localparam logic [7:0] START_LOW_OFFSET = 8'h00;
	localparam logic [7:0] START_HIGH_OFFSET = 8'h04;
	localparam logic [7:0] CH_BASE_OFFSET = 8'h10;
	localparam logic [7:0] CH_END_OFFSET = 8'h40;
	localparam int CH_INDEX_LSB = 3;
	localparam int COUNT_SEL_BIT = 2;

	// Start register layout
	localparam int RUN_LSB = 5;

	// Channel mode register layout
	localparam int MODE_LSB = 0;
	localparam int EDGE_LSB = 2;
	localparam int OVF_BIT = 5;
	localparam int PRED_BIT = 7;
	localparam int SRC_LSB = 8;

	// Count source indices
	localparam logic [2:0] SRC_DIV1 = 3'h0;
	localparam logic [2:0] SRC_DIV2 = 3'h1;
	localparam logic [2:0] SRC_DIV8 = 3'h2;
	localparam logic [2:0] SRC_DIV32 = 3'h3;
	localparam logic [2:0] SRC_DIV64 = 3'h4;
	localparam logic [2:0] SRC_SLOW_OSC = 3'h5;
	localparam logic [2:0] SRC_SUBCLOCK = 3'h6;

	// Prescaler terminal masks, tick when the low bits are all ones
	localparam logic [5:0] DIV2_MASK = 6'h01;
	localparam logic [5:0] DIV8_MASK = 6'h07;
	localparam logic [5:0] DIV32_MASK = 6'h1f;
	localparam logic [5:0] DIV64_MASK = 6'h3f;

	// Counter limits
	localparam logic [15:0] COUNT_ZERO = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hffff;
	localparam logic [15:0] COUNT_STEP = 16'h0001;

	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Operating modes
	typedef enum logic [1:0] {
		MODE_TIMER = 2'h0,
		MODE_EVENT = 2'h1,
		MODE_MEASURE = 2'h2,
		MODE_NONE = 2'h3
	} mode_e;

	// Per-channel configuration
	typedef struct packed {
		logic [2:0] clk_src;
		logic ev_pred;
		logic [1:0] edge_sel;
		mode_e mode;
	} cfg_s;

	localparam cfg_s CFG_RESET = '{clk_src: 3'h0, ev_pred: 1'b0, edge_sel: 2'h0, mode: MODE_TIMER};

	// Per-channel counter state
	typedef struct packed {
		logic [15:0] cnt;
		logic [15:0] reload;
		logic pin_d;
		logic armed;
		logic ovf;
		logic uf;
		logic irq;
	} chan_s;

	localparam chan_s CHAN_RESET = '0;

endpackage : timer_bank_pkg

// file: timer_channel.sv
// One 16-bit timer channel: down-counter, event counter or pulse measurer
`timescale 1ns/1ps
module timer_channel (
	input wire logic aclk,
	input wire logic aresetn,
	input timer_bank_pkg::cfg_s cfg,
	input wire logic run,
	input wire logic [7:0] ticks,
	input wire logic pin,
	input wire logic pred_uf,
	input wire logic wr,
	input wire logic [15:0] wval,
	input wire logic clr_ovf,
	output logic [15:0] count_rd,
	output logic ovf,
	output logic uf,
	output logic irq
);

	timer_bank_pkg::chan_s st;
	timer_bank_pkg::chan_s next_st;
	logic rise;
	logic fall;
	logic eff;
	logic src_tick;
	logic step;

	// Edge detection on the synchronised pin
	always_comb begin
		rise = pin & ~st.pin_d;
		fall = ~pin & st.pin_d;
		eff = cfg.edge_sel[1] ? (rise | fall) : (cfg.edge_sel[0] ? fall : rise);
		src_tick = ticks[cfg.clk_src];
		step = (cfg.mode == timer_bank_pkg::MODE_TIMER) ? src_tick :
			(cfg.ev_pred ? pred_uf : eff);
	end

	// Counter next state
	always_comb begin
		next_st = st;
		next_st.pin_d = pin;
		next_st.uf = 1'b0;
		next_st.irq = 1'b0;
		if (clr_ovf) begin
			next_st.ovf = 1'b0;
		end
		case (cfg.mode)
			timer_bank_pkg::MODE_TIMER, timer_bank_pkg::MODE_EVENT: begin
				if (run && step) begin
					if (st.cnt == timer_bank_pkg::COUNT_ZERO) begin
						next_st.cnt = st.reload;
						next_st.uf = 1'b1;
						next_st.irq = 1'b1;
					end else begin
						next_st.cnt = st.cnt - timer_bank_pkg::COUNT_STEP;
					end
				end
				if (wr) begin
					next_st.reload = wval;
					if (!run) begin
						next_st.cnt = wval;
					end
				end
			end
			timer_bank_pkg::MODE_MEASURE: begin
				if (run && eff) begin
					next_st.reload = st.cnt;
					next_st.cnt = timer_bank_pkg::COUNT_ZERO;
					next_st.irq = st.armed;
					next_st.armed = 1'b1;
				end else if (run && src_tick) begin
					if (st.cnt == timer_bank_pkg::COUNT_MAX) begin
						next_st.cnt = timer_bank_pkg::COUNT_ZERO;
						next_st.ovf = 1'b1;
						next_st.irq = 1'b1;
					end else begin
						next_st.cnt = st.cnt + timer_bank_pkg::COUNT_STEP;
					end
				end
			end
			default: begin
			end
		endcase
		if (!run) begin
			next_st.armed = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= timer_bank_pkg::CHAN_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign count_rd = (cfg.mode == timer_bank_pkg::MODE_MEASURE) ? st.reload : st.cnt;
	assign ovf = st.ovf;
	assign uf = st.uf;
	assign irq = st.irq;

endmodule : timer_channel

// file: timer_tick_source.sv
// Count-source tick generator: prescaler taps and synchronised slow clocks
`timescale 1ns/1ps
module timer_tick_source (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic slow_onchip_osc_clock,
	input wire logic subclock_source,
	output logic [7:0] ticks
);

	typedef struct packed {
		logic [5:0] div;
		logic [1:0] s1;
		logic [1:0] s2;
		logic [1:0] s3;
		logic [7:0] ticks;
	} tick_s;

	tick_s st;
	tick_s next_st;

	// Divider taps and rising edges of the two slow clocks
	always_comb begin
		next_st = st;
		next_st.div = st.div + 6'h01;
		next_st.s1 = {subclock_source, slow_onchip_osc_clock};
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		next_st.ticks = '0;
		next_st.ticks[timer_bank_pkg::SRC_DIV1] = 1'b1;
		next_st.ticks[timer_bank_pkg::SRC_DIV2] = &(st.div | ~timer_bank_pkg::DIV2_MASK);
		next_st.ticks[timer_bank_pkg::SRC_DIV8] = &(st.div | ~timer_bank_pkg::DIV8_MASK);
		next_st.ticks[timer_bank_pkg::SRC_DIV32] = &(st.div | ~timer_bank_pkg::DIV32_MASK);
		next_st.ticks[timer_bank_pkg::SRC_DIV64] = &(st.div | ~timer_bank_pkg::DIV64_MASK);
		next_st.ticks[timer_bank_pkg::SRC_SLOW_OSC] = st.s2[0] & ~st.s3[0];
		next_st.ticks[timer_bank_pkg::SRC_SUBCLOCK] = st.s2[1] & ~st.s3[1];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign ticks = st.ticks;

endmodule : timer_tick_source
